/* File: bmv_block_mover.sv */
/*
 * Four-channel block mover: per-channel registers, fixed-priority
 * channel selection, direct and indirect bus cycles.
 * Assumes single-clock bus cycles, same-clock on-chip request lines and
 * an arbiter that holds its grant while the bus request stays high.
 */
// What this block does
// - Requests come only from on-chip lines or software.
// - Obtain bus grant before any transfer cycle.
// - Fixed priority, channel 0 highest, resolved pre-cycle.
// - Acknowledge only in cycle touching requester.
// - On block end set status, interrupt, release.
// - Continue without release if continuous and requested.
// - Next request sampled after acknowledge drops; only indirect moves with direction clear do so.
// - Address update configurable independently per channel.
// - Fixed peripheral wiring of channels zero to three.
// - Direct mode: one cycle, data not latched.
// - Intermittent releases every cycle; continuous keeps bus.
// - Direct best rate three clocks or one.
// - Direct uses counter A; direction sets way.
// - Item size eight or sixteen bits selectable.
// - Direct: decrement length, update counter A.
// - Indirect: read to temp, then write.
// - Indirect best rate four clocks or two.
// - Indirect direction swaps A and B roles.
// - Indirect: update A, B, decrement length.
// - Four channels with eight registers each.
// - Software request bit presents a request.
// - Debug halt freezes all transfer activity.
`timescale 1ns/1ps
module bmv_block_mover #(
	parameter int AW = 16
) (
	// Clock and reset.
	input  wire logic                    i_clk,
	input  wire logic                    i_nrst,
	// Register port.
	input  wire logic [4:0]              i_reg_addr,
	input  wire logic [bmv_pkg::RDW-1:0] i_reg_wdata,
	input  wire logic                    i_reg_wr,
	input  wire logic                    i_reg_rd,
	output logic      [bmv_pkg::RDW-1:0] o_reg_rdata,
	// On-chip channel request lines and acknowledges.
	input  wire logic [bmv_pkg::NCH-1:0] i_req_pri,
	input  wire logic [bmv_pkg::NCH-1:0] i_req_sec,
	output logic      [bmv_pkg::NCH-1:0] o_ack,
	// System bus master side.
	output logic                         o_bus_req,
	input  wire logic                    i_bus_gnt,
	output logic      [AW-1:0]           o_bus_addr,
	output logic                         o_bus_rd,
	output logic                         o_bus_wr,
	output logic                         o_bus_wide,
	output logic                         o_bus_flyby,
	output logic      [15:0]             o_bus_wdata,
	input  wire logic [15:0]             i_bus_rdata,
	// Debug halt and interrupt.
	input  wire logic                    i_freeze,
	output logic                         o_irq
);
	import bmv_pkg::*;

	logic [AW-1:0]  addr_a_q  [NCH];
	logic [AW-1:0]  addr_b_q  [NCH];
	logic [AW-1:0]  rld_a_q   [NCH];
	logic [AW-1:0]  rld_b_q   [NCH];
	logic [15:0]    blen_q    [NCH];
	logic [15:0]    rld_len_q [NCH];
	logic [15:0]    ctrl_q    [NCH];
	logic [NCH-1:0] tc_q;
	logic [AW-1:0]  next_a    [NCH];
	logic [AW-1:0]  next_b    [NCH];
	logic [NCH-1:0] pend;
	logic [NCH-1:0] act;
	logic [NCH-1:0] ie;

	bmv_state_t     state_q;
	logic [1:0]     ch_q;
	bmv_state_t     state_d;
	logic [1:0]     ch_d;
	logic [15:0]    tmp_q;
	logic [15:0]    rdata_q;
	logic           irq_q;

	// Channel selection.
	logic [1:0]     win;
	logic           any_pend;
	logic [15:0]    cc;
	logic           cur_ind;
	logic           cur_dir;
	logic           item_end;
	logic           last;
	logic           cont;
	logic           upd;
	logic           run;

	wire [1:0] reg_ch  = i_reg_addr[4:3];
	wire [2:0] reg_idx = i_reg_addr[2:0];

	// A software write of one channel steers only that channel; eight
	// registers per channel keep the map regular.
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			wire          wr_c  = i_reg_wr && (reg_ch == 2'(c));
			wire          upd_c = upd && (ch_q == 2'(c));
			wire [AW-1:0] step  = ctrl_q[c][CB_WIDE] ? AW'(2) : AW'(1);
			wire          srcrq = ctrl_q[c][CB_SEC] ? i_req_sec[c] : i_req_pri[c];
			// One decode wire per register keeps each update block short.
			wire          wr_a    = wr_c && (reg_idx == REG_ADDR_A);
			wire          wr_ra   = wr_c && (reg_idx == REG_RLD_A);
			wire          wr_b    = wr_c && (reg_idx == REG_ADDR_B);
			wire          wr_rb   = wr_c && (reg_idx == REG_RLD_B);
			wire          wr_len  = wr_c && (reg_idx == REG_BLEN);
			wire          wr_rlen = wr_c && (reg_idx == REG_RLD_LEN);
			wire          wr_ctl  = wr_c && (reg_idx == REG_CTRL);
			wire          clr_tc  = wr_c && (reg_idx == REG_STAT) && i_reg_wdata[SB_TC];

			assign next_a[c] = !ctrl_q[c][CB_UPDA] ? addr_a_q[c] :
				(ctrl_q[c][CB_ADJA] ? addr_a_q[c] - step : addr_a_q[c] + step);
			assign next_b[c] = !ctrl_q[c][CB_UPDB] ? addr_b_q[c] :
				(ctrl_q[c][CB_ADJB] ? addr_b_q[c] - step : addr_b_q[c] + step);
			// Only on-chip lines and the software bit can raise a request.
			assign pend[c] = ctrl_q[c][CB_EN] && (blen_q[c] != 16'h0000) &&
				(ctrl_q[c][CB_SOFT_REQUEST_BIT] || srcrq);
			assign act[c] = (state_q != ST_IDLE) && (ch_q == 2'(c));
			assign ie[c]  = tc_q[c] && ctrl_q[c][CB_IE];

			// Hardware updates win over a software write to the same counter.
			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					addr_a_q[c] <= AW'(RST_REG);
				end else if (upd_c) begin
					addr_a_q[c] <= next_a[c];
				end else if (wr_a) begin
					addr_a_q[c] <= i_reg_wdata[AW-1:0];
				end
			end

			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					addr_b_q[c] <= AW'(RST_REG);
				end else if (upd_c && ctrl_q[c][CB_IND]) begin
					addr_b_q[c] <= next_b[c];
				end else if (wr_b) begin
					addr_b_q[c] <= i_reg_wdata[AW-1:0];
				end
			end

			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					blen_q[c] <= RST_REG;
				end else if (upd_c) begin
					blen_q[c] <= blen_q[c] - 16'h0001;
				end else if (wr_len) begin
					blen_q[c] <= i_reg_wdata;
				end
			end

			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					rld_a_q[c] <= AW'(RST_REG);
				end else if (wr_ra) begin
					rld_a_q[c] <= i_reg_wdata[AW-1:0];
				end
			end

			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					rld_b_q[c] <= AW'(RST_REG);
				end else if (wr_rb) begin
					rld_b_q[c] <= i_reg_wdata[AW-1:0];
				end
			end

			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					rld_len_q[c] <= RST_REG;
				end else if (wr_rlen) begin
					rld_len_q[c] <= i_reg_wdata;
				end
			end

			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					ctrl_q[c] <= RST_CTRL;
				end else if (wr_ctl) begin
					ctrl_q[c] <= i_reg_wdata;
				end
			end

			// Terminal count is write-one-to-clear; a new end wins.
			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					tc_q[c] <= 1'b0;
				end else if (upd_c && last) begin
					tc_q[c] <= 1'b1;
				end else if (clr_tc) begin
					tc_q[c] <= 1'b0;
				end
			end
		end
	endgenerate

	// Channel 0 wins; the loop runs downward so the lowest index is kept.
	always_comb begin
		win = 2'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pend[i]) begin
				win = 2'(i);
			end
		end
	end

	assign any_pend = |pend;
	assign cc       = ctrl_q[ch_q];
	assign cur_ind  = cc[CB_IND];
	assign cur_dir  = cc[CB_DIR];
	assign run      = !i_freeze;
	assign item_end = run && ((state_q == ST_X1 && !cur_ind) || state_q == ST_X2);
	assign last     = blen_q[ch_q] == 16'h0001;
	assign upd      = item_end;
	// The line is read in the item's last cycle; except in indirect moves with direction clear
	// that is also the acknowledge cycle, so the line seen is still the request being served.
	assign cont     = cc[CB_CONT] && !last && pend[ch_q];

	// Bus request is held from idle-with-work until the bus is handed back.
	assign o_bus_req = (state_q == ST_IDLE) ? any_pend : 1'b1;

	// Direct: counter A only. Indirect: direction swaps A and B.
	wire use_b = cur_ind && ((state_q == ST_X1) == cur_dir);
	wire in_x  = (state_q == ST_X1) || (state_q == ST_X2);
	wire on_a  = in_x && !use_b;
	wire hw_rq = !cc[CB_SOFT_REQUEST_BIT];

	assign o_bus_addr  = use_b ? addr_b_q[ch_q] : addr_a_q[ch_q];
	assign o_bus_rd    = run && (state_q == ST_X1) && (cur_ind || !cur_dir);
	assign o_bus_wr    = run && ((state_q == ST_X2) ||
		(state_q == ST_X1 && !cur_ind && cur_dir));
	assign o_bus_wide  = in_x && cc[CB_WIDE];
	assign o_bus_flyby = in_x && !cur_ind;
	assign o_bus_wdata = tmp_q;
	assign o_irq       = irq_q;

	// Acknowledge only in the cycle that reaches the requester side.
	generate
		for (c = 0; c < NCH; c++) begin : g_ack
			assign o_ack[c] = run && hw_rq && on_a && (ch_q == 2'(c));
		end
	endgenerate

	// Next state; a frozen engine keeps its state and channel.
	always_comb begin
		state_d = state_q;
		ch_d    = ch_q;
		if (run) begin
			case (state_q)
				ST_IDLE: begin
					if (i_bus_gnt && any_pend) begin
						state_d = ST_ARB;
						ch_d    = win;
					end
				end
				ST_ARB: begin
					state_d = ST_X1;
				end
				ST_X1: begin
					if (cur_ind) begin
						state_d = ST_X2;
					end else begin
						state_d = cont ? ST_X1 : ST_IDLE;
					end
				end
				ST_X2: begin
					state_d = cont ? ST_X1 : ST_IDLE;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			ch_q    <= 2'h0;
		end else begin
			state_q <= state_d;
			ch_q    <= ch_d;
		end
	end

	// The temporary register exists for indirect cycles only; direct data
	// flies past and is never held here.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tmp_q <= 16'h0000;
		end else if (run && state_q == ST_X1 && cur_ind) begin
			tmp_q <= i_bus_rdata;
		end
	end

	// The interrupt leaves a flop, so it lags the terminal count by one clock.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |ie;
		end
	end

	// Register readback.
	wire [15:0] stat_w = {14'h0000, act[reg_ch], tc_q[reg_ch]};
	logic [15:0] rsel;
	always_comb begin
		case (reg_idx)
			REG_ADDR_A:  rsel = 16'(addr_a_q[reg_ch]);
			REG_RLD_A:   rsel = 16'(rld_a_q[reg_ch]);
			REG_ADDR_B:  rsel = 16'(addr_b_q[reg_ch]);
			REG_RLD_B:   rsel = 16'(rld_b_q[reg_ch]);
			REG_BLEN:    rsel = blen_q[reg_ch];
			REG_RLD_LEN: rsel = rld_len_q[reg_ch];
			REG_CTRL:    rsel = ctrl_q[reg_ch];
			REG_STAT:    rsel = stat_w;
			default:     rsel = 16'h0000;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= i_reg_rd ? rsel : 16'h0000;
		end
	end

	assign o_reg_rdata = rdata_q;
endmodule : bmv_block_mover

/* File: bmv_partner.sv */
/* Bus arbiter, memory and request-line model facing the block mover.
   Assumes the mover holds its bus request while it owns the bus. */
`timescale 1ns/1ps
module bmv_partner (
	// Clock, reset and test controls.
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_slow,
	input  wire logic [3:0]  i_raise,
	// Mover side.
	input  wire logic        i_bus_req,
	input  wire logic        i_bus_rd,
	input  wire logic [15:0] i_bus_addr,
	input  wire logic [3:0]  i_ack,
	output logic             o_gnt,
	output logic [15:0]      o_rdata,
	output logic [3:0]       o_req
);
	logic [1:0]  wait_q;
	logic [15:0] noise_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_gnt <= 1'b0;
			wait_q <= 2'h0;
			o_req <= 4'h0;
			noise_q <= 16'h0000;
		end else begin
			o_gnt <= i_bus_req && (o_gnt || wait_q == {i_slow, i_slow});
			wait_q <= i_bus_req ? wait_q + 2'h1 : 2'h0;
			o_req <= (o_req | i_raise) & ~i_ack;
			noise_q <= noise_q + 16'h3b1d;
		end
	end
	// Outside a read the data lines wander, so stale data is never seen as valid.
	assign o_rdata = i_bus_rd ? (i_bus_addr ^ 16'h5aa5) : noise_q;
endmodule : bmv_partner

/* File: bmv_pkg.sv */
/*
 * Shared constants for the four-channel block mover: register
 * indices, control and status bit positions, reset values and states.
 * Assumes a 16-bit register port with a 5-bit word address.
 */
package bmv_pkg;
	localparam int NCH = 4;
	localparam int RDW = 16;

	// Register index inside a channel; address bits [4:3] pick the channel.
	localparam logic [2:0] REG_ADDR_A  = 3'h0;
	localparam logic [2:0] REG_RLD_A   = 3'h1;
	localparam logic [2:0] REG_ADDR_B  = 3'h2;
	localparam logic [2:0] REG_RLD_B   = 3'h3;
	localparam logic [2:0] REG_BLEN    = 3'h4;
	localparam logic [2:0] REG_RLD_LEN = 3'h5;
	localparam logic [2:0] REG_CTRL    = 3'h6;
	localparam logic [2:0] REG_STAT    = 3'h7;

	// Control register fields.
	localparam int CB_EN   = 0;
	localparam int CB_SOFT_REQUEST_BIT = 1;
	localparam int CB_DIR  = 2;
	localparam int CB_IND  = 3;
	localparam int CB_CONT = 4;
	localparam int CB_WIDE = 5;
	localparam int CB_UPDA = 6;
	localparam int CB_ADJA = 7;
	localparam int CB_UPDB = 8;
	localparam int CB_ADJB = 9;
	localparam int CB_IE   = 10;
	localparam int CB_SEC  = 11;

	// Status register fields.
	localparam int SB_TC  = 0;
	localparam int SB_ACT = 1;

	localparam logic [15:0] RST_REG  = 16'h0000;
	localparam logic [15:0] RST_CTRL = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARB  = 2'b01,
		ST_X1   = 2'b10,
		ST_X2   = 2'b11
	} bmv_state_t;
endpackage : bmv_pkg

/* File: bmv_props.sv */
/* Bus, acknowledge and interrupt checks for the block mover.
   Assumes one clock domain with an asynchronous active-low reset. */
`timescale 1ns/1ps
module bmv_props (
	// Clock, reset and inputs.
	input wire logic        i_clk,
	input wire logic        i_nrst,
	input wire logic        i_reg_wr,
	input wire logic        i_bus_gnt,
	input wire logic [15:0] i_bus_rdata,
	input wire logic        i_freeze,
	// Outputs.
	input wire logic [3:0]  o_ack,
	input wire logic        o_bus_req,
	input wire logic        o_bus_rd,
	input wire logic        o_bus_wr,
	input wire logic        o_bus_flyby,
	input wire logic        o_bus_wide,
	input wire logic [15:0] o_bus_wdata,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	wire logic stb = o_bus_rd | o_bus_wr;
	property p_gnt; stb |-> i_bus_gnt; endproperty
	a_gnt: assert property (p_gnt) else $error("bus cycle without grant");
	property p_req; stb |-> o_bus_req; endproperty
	a_req: assert property (p_req) else $error("bus cycle without request");
	property p_ack; |o_ack |-> stb; endproperty
	a_ack: assert property (p_ack) else $error("acknowledge outside a bus cycle");
	property p_pri; $onehot0(o_ack); endproperty
	a_pri: assert property (p_pri) else $error("two channels acknowledged");
	property p_frz; i_freeze |-> !stb && o_ack == 4'h0; endproperty
	a_frz: assert property (p_frz) else $error("activity while frozen");
	property p_one; !(o_bus_rd && o_bus_wr); endproperty
	a_one: assert property (p_one) else $error("read and write together");
	property p_ind; o_bus_rd && !o_bus_flyby |=> o_bus_wr || i_freeze; endproperty
	a_ind: assert property (p_ind) else $error("indirect read not followed by write");
	property p_tmp; o_bus_rd && !o_bus_flyby |=> o_bus_wdata == $past(i_bus_rdata); endproperty
	a_tmp: assert property (p_tmp) else $error("indirect write data differs from read");
	property p_irq; $fell(o_irq) |-> $past(i_reg_wr, 2); endproperty
	a_irq: assert property (p_irq) else $error("interrupt dropped without software");
	property p_wide; o_bus_wide && !i_freeze |-> stb; endproperty
	a_wide: assert property (p_wide) else $error("item size shown outside a bus cycle");
endmodule : bmv_props

bind bmv_block_mover bmv_props u_props (.i_clk, .i_nrst, .i_reg_wr, .i_bus_gnt, .i_bus_rdata, .i_freeze,
	.o_ack, .o_bus_req, .o_bus_rd, .o_bus_wr, .o_bus_flyby, .o_bus_wide, .o_bus_wdata, .o_irq);

/* File: tb_top.sv */
/* Self-checking bench for the block mover: a table of block moves, then
   priority, freeze and reset cases. Assumes bmv_partner on the bus side. */
`timescale 1ns/1ps
module tb_top;
	import bmv_pkg::*;
	typedef struct {logic [15:0] ctrl, a_end, b_end, rd_addr; int n, span;} bmv_row_t;
	bmv_row_t rows [4] = '{
		'{16'h0043, 16'h0103, 16'h0200, 16'h0100, 3, 6},
		'{16'h00f3, 16'h00fa, 16'h0200, 16'h0100, 3, 2},
		'{16'h011f, 16'h0100, 16'h0203, 16'h0200, 6, 5},
		'{16'h077b, 16'h0106, 16'h01fa, 16'h0100, 6, 5}};
	logic clk = 0, nrst = 0, wr = 0, rd = 0, freeze = 0, slow = 0;
	logic [4:0] adr = 0;
	logic [15:0] wd = 0, rdata, baddr, bwdata, brdata;
	logic [3:0] raise = 0, sec = 0, ack, req;
	logic bus_req, gnt, brd, bwr, irq;
	logic [15:0] rdq[$];
	logic [3:0] ackq[$];
	int tq[$];
	int cyc = 0, checks = 0, fail_count = 0;
	bmv_block_mover uut (.i_clk(clk), .i_nrst(nrst), .i_reg_addr(adr), .i_reg_wdata(wd), .i_reg_wr(wr),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .i_req_pri(req & ~sec), .i_req_sec(req & sec), .o_ack(ack),
		.o_bus_req(bus_req), .i_bus_gnt(gnt), .o_bus_addr(baddr), .o_bus_rd(brd), .o_bus_wr(bwr),
		.o_bus_wide(), .o_bus_flyby(), .o_bus_wdata(bwdata), .i_bus_rdata(brdata), .i_freeze(freeze), .o_irq(irq));
	bmv_partner u_far (.i_clk(clk), .i_nrst(nrst), .i_slow(slow), .i_raise(raise), .i_bus_req(bus_req),
		.i_bus_rd(brd), .i_bus_addr(baddr), .i_ack(ack), .o_gnt(gnt), .o_rdata(brdata), .o_req(req));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (brd === 1'b1) rdq.push_back(baddr);
		if ((brd | bwr) === 1'b1) tq.push_back(cyc);
		if (|ack) ackq.push_back(ack);
	end
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic rd_cmp(input string what, input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp(what, exp, rdata);
	endtask : rd_cmp
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test
	task automatic wait_idle;
		int i;
		repeat (2) @(posedge clk);
		for (i = 0; i < 300 && bus_req !== 1'b0; i++) @(posedge clk);
		if (i == 300) begin
			fail_count++;
			stop_test;
		end
	endtask : wait_idle
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd_cmp("ctrl reset", {2'd3, REG_CTRL}, RST_CTRL);
		// Indirect rows move memory to memory, so software picks indirect there.
		foreach (rows[k]) begin
			reg_wr({2'd0, REG_ADDR_A}, 16'h0100);
			reg_wr({2'd0, REG_ADDR_B}, 16'h0200);
			reg_wr({2'd0, REG_BLEN}, 16'h0003);
			rdq.delete();
			tq.delete();
			reg_wr({2'd0, REG_CTRL}, rows[k].ctrl);
			wait_idle;
			rd_cmp("addr a", {2'd0, REG_ADDR_A}, rows[k].a_end);
			rd_cmp("addr b", {2'd0, REG_ADDR_B}, rows[k].b_end);
			rd_cmp("length", {2'd0, REG_BLEN}, 16'h0000);
			rd_cmp("status", {2'd0, REG_STAT}, 16'h0001);
			cmp("irq", {15'h0, rows[k].ctrl[CB_IE]}, {15'h0, irq});
			cmp("cycles", 16'(rows[k].n), 16'(tq.size()));
			cmp("read addr", rows[k].rd_addr, rdq[0]);
			cmp("span", 16'(rows[k].span), 16'(tq[$] - tq[0]));
			reg_wr({2'd0, REG_CTRL}, 16'h0000);
			reg_wr({2'd0, REG_STAT}, 16'h0001);
			$display("row %0d done", k);
		end
		slow <= 1'b1;
		sec <= 4'b0100;
		// Channel 2 listens to its secondary line only.
		for (int c = 0; c < 3; c++) begin
			reg_wr({c[1:0], REG_BLEN}, 16'h0001);
			reg_wr({c[1:0], REG_CTRL}, {4'h0, c == 2, 10'h000, c != 0});
		end
		ackq.delete();
		@(posedge clk) raise <= 4'b0111;
		@(posedge clk) raise <= 4'b0000;
		wait_idle;
		cmp("acks", 16'h0002, 16'(ackq.size()));
		cmp("first ack", 16'h0002, {12'h0, ackq[0]});
		cmp("second ack", 16'h0004, {12'h0, ackq[1]});
		$display("priority done");
		@(posedge clk) freeze <= 1'b1;
		reg_wr({2'd3, REG_BLEN}, 16'h0002);
		reg_wr({2'd3, REG_CTRL}, 16'h0003);
		repeat (20) @(posedge clk);
		rd_cmp("frozen length", {2'd3, REG_BLEN}, 16'h0002);
		@(posedge clk) freeze <= 1'b0;
		wait_idle;
		rd_cmp("resumed length", {2'd3, REG_BLEN}, 16'h0000);
		$display("freeze done");
		// Reset after a block is requested but before its first item moves must drop the bus and clear the counters.
		reg_wr({2'd3, REG_BLEN}, 16'h0004);
		reg_wr({2'd3, REG_CTRL}, 16'h0003);
		repeat (3) @(posedge clk);
		nrst <= 1'b0;
		@(posedge clk) nrst <= 1'b1;
		cmp("reset bus req", 16'h0000, {15'h0, bus_req});
		rd_cmp("reset length", {2'd3, REG_BLEN}, RST_REG);
		rd_cmp("reset ctrl", {2'd3, REG_CTRL}, RST_CTRL);
		$display("reset done");
		stop_test;
	end
endmodule : tb_top
